// ==== src/can_msg_status_irq_id.sv ====
// Module: message handler status vectors, interrupt identifier and AXI4-Lite slave
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module can_msg_status_irq_id
   import msg_status_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_WIDTH-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_WIDTH-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Message handler side
   input wire bit_update_type handler_tx_request,
   input wire bit_update_type handler_fresh_payload,
   input wire bit_update_type handler_irq_pending,
   // Interface register sets (processor path into the objects)
   input wire bit_update_type cpu_tx_request,
   input wire bit_update_type cpu_fresh_payload,
   input wire bit_update_type cpu_irq_pending,
   input wire bit_update_type cpu_object_valid,
   // Protocol core status interrupt event
   input wire logic status_event,
   output logic status_reg_read,
   output logic [NUM_OBJECTS-1:0] eligible_objects,
   output logic irq_out
);
   // ==========================================================
   // Status vectors
   logic [NUM_OBJECTS-1:0] tx_request;
   logic [NUM_OBJECTS-1:0] fresh_payload_flag;
   logic [NUM_OBJECTS-1:0] object_irq_pending;
   logic [NUM_OBJECTS-1:0] object_valid;
   localparam bit_update_type NO_UPDATE = '0;

   status_vector #(.WIDTH(NUM_OBJECTS)) u_tx_request (
      .aclk(aclk),
      .aresetn(aresetn),
      .handler_upd(handler_tx_request),
      .cpu_upd(cpu_tx_request),
      .vec(tx_request)
   );

   status_vector #(.WIDTH(NUM_OBJECTS)) u_fresh_payload (
      .aclk(aclk),
      .aresetn(aresetn),
      .handler_upd(handler_fresh_payload),
      .cpu_upd(cpu_fresh_payload),
      .vec(fresh_payload_flag)
   );

   // Pending bits only fall on an explicit clear mask
   status_vector #(.WIDTH(NUM_OBJECTS)) u_irq_pending (
      .aclk(aclk),
      .aresetn(aresetn),
      .handler_upd(handler_irq_pending),
      .cpu_upd(cpu_irq_pending),
      .vec(object_irq_pending)
   );

   // The handler has no path into the valid bits
   status_vector #(.WIDTH(NUM_OBJECTS)) u_object_valid (
      .aclk(aclk),
      .aresetn(aresetn),
      .handler_upd(NO_UPDATE),
      .cpu_upd(cpu_object_valid),
      .vec(object_valid)
   );

   // Handler scans only configured objects
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eligible_objects <= VECTOR_RESET;
      end else begin
         eligible_objects <= object_valid;
      end
   end

   // ==========================================================
   // Status interrupt
   logic status_irq_reg;
   logic global_interrupt_enable_reg;
   logic rd_take;
   logic [ADDR_WIDTH-1:0] rd_addr;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign rd_addr = {s_axi_araddr[ADDR_WIDTH-1:2], 2'b00};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_irq_reg <= 1'b0;
      end else if (status_event) begin
         status_irq_reg <= 1'b1;
      end else if (rd_take && rd_addr == OFS_STATUS) begin
         status_irq_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_reg_read <= 1'b0;
      end else begin
         status_reg_read <= rd_take && rd_addr == OFS_STATUS;
      end
   end

   // ==========================================================
   // Identifier and interrupt line
   irq_id_type id_now;
   irq_priority #(.WIDTH(NUM_OBJECTS)) u_priority (
      .status_irq(status_irq_reg),
      .pending(object_irq_pending),
      .result(id_now)
   );

   // Follows the identifier, gated by the global interrupt enable, with one register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= id_now.active && global_interrupt_enable_reg;
      end
   end

   // ==========================================================
   // AXI4-Lite write channel: only the control word is writable
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_WIDTH-1:0] aw_addr_reg;
   logic [DATA_WIDTH-1:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_go;
   assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= {s_axi_awaddr[ADDR_WIDTH-1:2], 2'b00};
      end else if (wr_go) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= WORD_ZERO;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         global_interrupt_enable_reg <= 1'b0;
      end else if (wr_go && aw_addr_reg == OFS_CONTROL && w_strb_reg[0]) begin
         global_interrupt_enable_reg <= w_data_reg[CTRL_ENABLE_BIT];
      end
   end

   // Status words ignore writes and answer with an error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr_reg == OFS_CONTROL) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   logic [DATA_WIDTH-1:0] rd_word;
   logic rd_hit;
   always_comb begin
      rd_word = WORD_ZERO;
      rd_hit = 1'b1;
      unique case (rd_addr)
         OFS_INTERRUPT_SOURCE_ID: rd_word = {16'h0000, id_now.id};
         OFS_TX_REQUEST_LOW: rd_word = {16'h0000, tx_request[HALF_OBJECTS-1:0]};
         OFS_TX_REQUEST_HIGH: rd_word = {16'h0000, tx_request[NUM_OBJECTS-1:HALF_OBJECTS]};
         OFS_FRESH_PAYLOAD_LOW: rd_word = {16'h0000, fresh_payload_flag[HALF_OBJECTS-1:0]};
         OFS_FRESH_PAYLOAD_HIGH:
            rd_word = {16'h0000, fresh_payload_flag[NUM_OBJECTS-1:HALF_OBJECTS]};
         OFS_OBJECT_IRQ_PENDING_LOW:
            rd_word = {16'h0000, object_irq_pending[HALF_OBJECTS-1:0]};
         OFS_OBJECT_IRQ_PENDING_HIGH:
            rd_word = {16'h0000, object_irq_pending[NUM_OBJECTS-1:HALF_OBJECTS]};
         OFS_OBJECT_VALID_LOW: rd_word = {16'h0000, object_valid[HALF_OBJECTS-1:0]};
         OFS_OBJECT_VALID_HIGH:
            rd_word = {16'h0000, object_valid[NUM_OBJECTS-1:HALF_OBJECTS]};
         OFS_CONTROL: rd_word = {31'h0000_0000, global_interrupt_enable_reg};
         OFS_STATUS: rd_word = {31'h0000_0000, status_irq_reg};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_take && !s_axi_arready;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= WORD_ZERO;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Helper terms: objects below the reported one, pending bits with no clear this cycle
   logic [NUM_OBJECTS-1:0] below_id_mask;
   logic [NUM_OBJECTS-1:0] pending_kept;
   assign below_id_mask = (NUM_OBJECTS'(1) << 5'(id_now.id - 16'h0001)) - NUM_OBJECTS'(1);
   assign pending_kept = object_irq_pending & ~handler_irq_pending.clr_mask &
      ~cpu_irq_pending.clr_mask;

   a_id_zero_idle: assert property (
      (!status_irq_reg && object_irq_pending == '0) |-> id_now.id == ID_NONE)
      else $error("identifier nonzero with nothing pending");
   a_id_range_obj: assert property (
      (!status_irq_reg && object_irq_pending != '0) |->
         (id_now.id >= 16'h0001 && id_now.id <= 16'h0020))
      else $error("object identifier out of range");
   a_status_first: assert property (
      status_irq_reg |-> id_now.id == ID_STATUS)
      else $error("status interrupt not reported first");
   a_lowest_object: assert property (
      (!status_irq_reg && object_irq_pending[0]) |-> id_now.id == 16'h0001)
      else $error("lowest object not reported first");
   a_id_tracks_pnd: assert property (
      (!status_irq_reg && id_now.active && !status_event) |->
         object_irq_pending[5'(id_now.id - 16'h0001)])
      else $error("identifier does not match a pending bit");
   a_irq_follows: assert property (
      (id_now.active && global_interrupt_enable_reg) |=> irq_out)
      else $error("interrupt line not raised");
   a_irq_drops: assert property (
      (!id_now.active || !global_interrupt_enable_reg) |=> !irq_out)
      else $error("interrupt line stuck");
   a_pending_sticky: assert property (
      (object_irq_pending[0] && !handler_irq_pending.clr_mask[0] &&
         !cpu_irq_pending.clr_mask[0]) |=> object_irq_pending[0])
      else $error("pending bit dropped without a clear");
   a_status_clear: assert property (
      (rd_take && rd_addr == OFS_STATUS && !status_event) |=> !status_irq_reg)
      else $error("status read did not clear status interrupt");
   a_valid_cpu_only: assert property (
      (cpu_object_valid == '0) |=> $stable(object_valid))
      else $error("valid bits changed without processor write");
   a_read_answer: assert property (
      rd_take |=> s_axi_rvalid ##0 $past(rd_word) == s_axi_rdata)
      else $error("read answer late or wrong");
   a_no_lower_pending: assert property (
      (!status_irq_reg && id_now.active) |-> (object_irq_pending & below_id_mask) == '0)
      else $error("a lower pending object was skipped");
   a_id_codes_used: assert property (
      id_now.id <= 16'h0020 || id_now.id == ID_STATUS)
      else $error("identifier shows an unused code");
   a_pending_all_kept: assert property (
      1'b1 |=> ($past(pending_kept) & ~object_irq_pending) == '0)
      else $error("pending bit dropped without a clear");
   a_status_pulse: assert property (
      (rd_take && rd_addr == OFS_STATUS) |=> status_reg_read)
      else $error("status read pulse missing");
   a_eligible_copy: assert property (
      1'b1 |=> eligible_objects == $past(object_valid))
      else $error("eligible objects do not follow valid bits");
   a_ro_no_effect: assert property (
      (wr_go && aw_addr_reg != OFS_CONTROL) |=> $stable(global_interrupt_enable_reg))
      else $error("write to a status word changed state");
   a_tx_only_events: assert property (
      (handler_tx_request == '0 && cpu_tx_request == '0) |=> $stable(tx_request))
      else $error("transmit request changed without an update");
   a_fresh_only_events: assert property (
      (handler_fresh_payload == '0 && cpu_fresh_payload == '0) |=>
         $stable(fresh_payload_flag))
      else $error("fresh payload flag changed without an update");

   c_status_irq: cover property (status_event ##1 irq_out);
   c_obj_irq: cover property ($rose(object_irq_pending[31]) ##[1:4] irq_out);
   c_both_pending: cover property (status_irq_reg && object_irq_pending != '0);
   c_id_read: cover property (rd_take && rd_addr == OFS_INTERRUPT_SOURCE_ID);
   c_status_cleared: cover property (status_reg_read ##1 !status_irq_reg);
endmodule

// ==== src/irq_priority.sv ====
// Module: combinational priority encoder for the interrupt source identifier
`timescale 1ns/1ps
module irq_priority
   import msg_status_pkg::*;
#(
   parameter int unsigned WIDTH = NUM_OBJECTS
) (
   input wire logic status_irq,
   input wire logic [WIDTH-1:0] pending,
   output irq_id_type result
);
   always_comb begin
      result.id = ID_NONE;
      result.active = 1'b0;
      // Scan downward so the lowest object number is left standing
      for (int i = WIDTH - 1; i >= 0; i--) begin
         if (pending[i]) begin
            result.id = 16'(i + 1);
            result.active = 1'b1;
         end
      end
      if (status_irq) begin
         result.id = ID_STATUS;
         result.active = 1'b1;
      end
   end
endmodule

// ==== src/msg_status_pkg.sv ====
// Package: register map, field widths and carrier types of the message status block
package msg_status_pkg;
   localparam int unsigned NUM_OBJECTS = 32;
   localparam int unsigned HALF_OBJECTS = 16;
   localparam int unsigned ID_WIDTH = 16;
   localparam int unsigned ADDR_WIDTH = 12;
   localparam int unsigned DATA_WIDTH = 32;

   // Register byte addresses
   localparam logic [11:0] OFS_INTERRUPT_SOURCE_ID = 12'h010;
   localparam logic [11:0] OFS_TX_REQUEST_LOW = 12'h100;
   localparam logic [11:0] OFS_TX_REQUEST_HIGH = 12'h104;
   localparam logic [11:0] OFS_FRESH_PAYLOAD_LOW = 12'h120;
   localparam logic [11:0] OFS_FRESH_PAYLOAD_HIGH = 12'h124;
   localparam logic [11:0] OFS_OBJECT_IRQ_PENDING_LOW = 12'h140;
   localparam logic [11:0] OFS_OBJECT_IRQ_PENDING_HIGH = 12'h144;
   localparam logic [11:0] OFS_OBJECT_VALID_LOW = 12'h160;
   localparam logic [11:0] OFS_OBJECT_VALID_HIGH = 12'h164;
   localparam logic [11:0] OFS_CONTROL = 12'h200;
   localparam logic [11:0] OFS_STATUS = 12'h204;

   localparam logic [15:0] ID_NONE = 16'h0000;
   localparam logic [15:0] ID_STATUS = 16'h8000;
   localparam logic [31:0] VECTOR_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam int unsigned CTRL_ENABLE_BIT = 0;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Per-object update carried from the message handler and the interface registers
   typedef struct packed {
      logic [31:0] set_mask;
      logic [31:0] clr_mask;
   } bit_update_type;

   typedef struct packed {
      logic [15:0] id;
      logic active;
   } irq_id_type;
endpackage

// ==== src/status_vector.sv ====
// Module: one 32-bit per-object status vector with set and clear masks
`timescale 1ns/1ps
module status_vector
   import msg_status_pkg::*;
#(
   parameter int unsigned WIDTH = NUM_OBJECTS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire bit_update_type handler_upd,
   input wire bit_update_type cpu_upd,
   output logic [WIDTH-1:0] vec
);
   // Set wins over clear so an event in the clearing cycle is kept
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               vec[i] <= VECTOR_RESET[i];
            end else if (handler_upd.set_mask[i] || cpu_upd.set_mask[i]) begin
               vec[i] <= 1'b1;
            end else if (handler_upd.clr_mask[i] || cpu_upd.clr_mask[i]) begin
               vec[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule

// ==== test/can_msg_status_irq_id_tb.sv ====
// Testbench: register map, vectors and interrupt identifier over AXI4-Lite
`timescale 1ns/1ps
module can_msg_status_irq_id_tb;
   import msg_status_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq_out, stat_rd;
   logic [1:0] bresp, rresp;
   logic [31:0] eligible;
   logic cmd_valid = 1'b0, cmd_set = 1'b0, status_event;
   logic [2:0] cmd_sel = '0;
   logic [4:0] cmd_obj = '0;
   bit_update_type upd [0:7];
   int mismatches = 0;
   int comparisons = 0;
   int status_reads = 0;

   always #20 aclk = ~aclk;

   // Counts status-read pulses seen from the block
   always @(posedge aclk) begin
      if (stat_rd === 1'b1) begin
         status_reads <= status_reads + 1;
      end
   end

   object_event_source object_event_source_inst (.aclk(aclk), .cmd_valid(cmd_valid),
      .cmd_sel(cmd_sel), .cmd_set(cmd_set), .cmd_obj(cmd_obj), .upd(upd),
      .status_event(status_event));

   can_msg_status_irq_id can_msg_status_irq_id_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .handler_tx_request(upd[0]), .handler_fresh_payload(upd[1]),
      .handler_irq_pending(upd[2]), .cpu_tx_request(upd[4]), .cpu_fresh_payload(upd[5]),
      .cpu_irq_pending(upd[6]), .cpu_object_valid(upd[7]), .status_event(status_event),
      .status_reg_read(stat_rd), .eligible_objects(eligible), .irq_out(irq_out));

   // ==========================================
   // Shared tasks
   task automatic complete_run();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Ready and valid are sampled mid-cycle: design outputs only move at rising edges
   task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic go, rv;
      logic [31:0] rd;
      logic [1:0] rr;
      rv = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40 && !rv; n++) begin
         @(negedge aclk);
         go = arready;
         rv = rvalid;
         rd = rdata;
         rr = rresp;
         @(posedge aclk);
         if (go) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      // One edge apart, so a following call never re-raises rready in this step
      @(posedge aclk);
      if (!rv) begin
         mismatches++;
         complete_run();
      end
      check(rd, ed);
      check({30'h0, rr}, {30'h0, er});
   endtask

   task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] br;
      b = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40 && !b; n++) begin
         @(negedge aclk);
         aw = awready;
         w = wready;
         b = bvalid;
         br = bresp;
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      @(posedge aclk);
      if (!b) begin
         mismatches++;
         complete_run();
      end
      check({30'h0, br}, {30'h0, er});
   endtask

   task automatic ev(input logic [2:0] sel, input logic set, input logic [4:0] obj);
      cmd_sel <= sel;
      cmd_set <= set;
      cmd_obj <= obj;
      cmd_valid <= 1'b1;
      @(posedge aclk);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask

   // ==========================================
   // Scenarios
   task automatic test_reset();
      logic [11:0] map [9] = '{12'h010, 12'h100, 12'h104, 12'h120, 12'h124,
                               12'h140, 12'h144, 12'h160, 12'h164};
      foreach (map[i]) axr(map[i], 32'h0000_0000, RESP_OKAY);
      axr(12'h300, 32'h0000_0000, RESP_SLVERR);
      axw(12'h140, 32'hffff_ffff, RESP_SLVERR);
      axr(12'h140, 32'h0000_0000, RESP_OKAY);
   endtask

   task automatic test_vectors();
      ev(3'd0, 1'b1, 5'd0);
      ev(3'd4, 1'b1, 5'd31);
      axr(12'h100, 32'h0000_0001, RESP_OKAY);
      axr(12'h104, 32'h0000_8000, RESP_OKAY);
      ev(3'd0, 1'b0, 5'd0);
      axr(12'h100, 32'h0000_0000, RESP_OKAY);
      ev(3'd1, 1'b1, 5'd16);
      ev(3'd5, 1'b1, 5'd1);
      axr(12'h120, 32'h0000_0002, RESP_OKAY);
      axr(12'h124, 32'h0000_0001, RESP_OKAY);
      ev(3'd7, 1'b1, 5'd4);
      axr(12'h160, 32'h0000_0010, RESP_OKAY);
      check(eligible, 32'h0000_0010);
   endtask

   task automatic test_priority();
      axw(OFS_CONTROL, 32'h0000_0001, RESP_OKAY);
      ev(3'd2, 1'b1, 5'd4);
      ev(3'd2, 1'b1, 5'd2);
      axr(12'h010, 32'h0000_0003, RESP_OKAY);
      check({31'h0, irq_out}, 32'h0000_0001);
      ev(3'd2, 1'b1, 5'd31);
      ev(3'd3, 1'b0, 5'd0);
      axr(12'h010, 32'h0000_8000, RESP_OKAY);
      axr(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
      repeat (20) @(posedge aclk);
      check(status_reads, 32'h0000_0001);
      axr(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
      axr(12'h010, 32'h0000_0003, RESP_OKAY);
      ev(3'd6, 1'b0, 5'd2);
      axr(12'h010, 32'h0000_0005, RESP_OKAY);
      ev(3'd6, 1'b0, 5'd4);
      axr(12'h010, 32'h0000_0020, RESP_OKAY);
      axr(12'h144, 32'h0000_8000, RESP_OKAY);
      axw(OFS_CONTROL, 32'h0000_0000, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check({31'h0, irq_out}, 32'h0000_0000);
      axw(OFS_CONTROL, 32'h0000_0001, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check({31'h0, irq_out}, 32'h0000_0001);
      // Without byte lane 0 the enable must not move
      wstrb <= 4'he;
      axw(OFS_CONTROL, 32'h0000_0000, RESP_OKAY);
      wstrb <= 4'hf;
      axr(OFS_CONTROL, 32'h0000_0001, RESP_OKAY);
      ev(3'd2, 1'b0, 5'd31);
      axr(12'h010, 32'h0000_0000, RESP_OKAY);
      check({31'h0, irq_out}, 32'h0000_0000);
      ev(3'd2, 1'b1, 5'd1);
      ev(3'd6, 1'b1, 5'd0);
      axr(12'h010, 32'h0000_0001, RESP_OKAY);
      ev(3'd6, 1'b0, 5'd0);
      axr(12'h010, 32'h0000_0002, RESP_OKAY);
   endtask

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      test_reset();
      test_vectors();
      test_priority();
      complete_run();
   end
endmodule

// ==== test/object_event_source.sv ====
// Partner model: handler and interface-register events as one-cycle mask pulses
`timescale 1ns/1ps
module object_event_source
   import msg_status_pkg::*;
(
   input wire logic aclk,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_sel,
   input wire logic cmd_set,
   input wire logic [4:0] cmd_obj,
   output bit_update_type upd [0:7],
   output logic status_event
);
   // ==========================================
   // Event pulses
   // Select 3 stands for the status event; the rest pick one mask source
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 8; i++) begin
         upd[i] <= '0;
      end
      status_event <= 1'b0;
      if (cmd_valid) begin
         if (cmd_sel == 3'd3) begin
            status_event <= 1'b1;
         end else if (cmd_set) begin
            upd[cmd_sel].set_mask[cmd_obj] <= 1'b1;
         end else begin
            upd[cmd_sel].clr_mask[cmd_obj] <= 1'b1;
         end
      end
   end
endmodule
